// file: dv/srcv_ctrl_asserts.sv
`timescale 1ns/1ps
module srcv_ctrl_asserts
  import srcv_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chan_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire srcv_ext_s ext_in,
  input wire logic tx_empty_evt,
  input wire logic local_loop,
  input wire logic six_bit_sync,
  input wire logic tx_irq,
  input wire logic ext_irq,
  input wire logic rx_gate,
  input wire logic fifo_we,
  input wire logic [7:0] fifo_data
);
  // ------------------------------------------------
  // Register shadow, word index from the bus address
  // ------------------------------------------------
  logic [7:0] sh [0:15];
  logic rd_p, wr_p;
  logic [3:0] ix;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_p <= 1'b0;
      wr_p <= 1'b0;
      ix <= 4'h0;
    end else begin
      rd_p <= hsel && hready && htrans[1] && !hwrite;
      wr_p <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        ix <= haddr[5:2];
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        sh[i] <= 8'h00;
      end
    end else begin
      if (wr_p) begin
        sh[ix] <= hwdata[7:0];
      end
      if (chan_rst) begin
        sh[1][0] <= 1'b0;
        sh[3][0] <= 1'b0;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_bus_okay: assert property (!hresp && hreadyout)
    else $error("bus answer not okay and ready");
  chk_vec_a_read: assert property (rd_p && ix == 4'h2 |->
    hrdata == {24'h000000, sh[2]}) else $error("vector via A wrong");
  chk_vec_b_low: assert property (rd_p && ix == 4'hB && !sh[6][4] |->
    {hrdata[7:4], hrdata[0]} == {sh[2][7:4], sh[2][0]})
    else $error("vector via B low mode wrong");
  chk_vec_b_high: assert property (rd_p && ix == 4'hB && sh[6][4] |->
    {hrdata[7], hrdata[3:0]} == {sh[2][7], sh[2][3:0]})
    else $error("vector via B high mode wrong");
  chk_rpr_gated: assert property (rd_p && ix == 4'hA |->
    hrdata[7:0] == ((sh[7][0] && sh[5][6]) ? (sh[3] & 8'hEF) : 8'h00))
    else $error("parameter readback gate wrong");
  chk_tx_irq_cause: assert property (tx_irq |->
    $past(tx_empty_evt) && $past(sh[1][1])) else $error("stray tx irq");
  chk_ext_master: assert property (ext_irq |-> $past(sh[1][0]))
    else $error("ext irq with master off");
  chk_rx_enable: assert property (rx_gate |-> sh[3][0] || $past(sh[3][0]))
    else $error("receiver on while disabled");
  chk_auto_dcd: assert property (rx_gate && $past(sh[3][5]) &&
    !$past(local_loop) |-> $past(ext_in.dcd)) else $error("dcd ignored");
  chk_async_fill: assert property (fifo_we && sh[12][1:0] == 2'b00 &&
    sh[3][7:6] == 2'b00 |-> fifo_data[7:5] == 3'h7)
    else $error("async fill bits not ones");
  chk_sync_strip: assert property (fifo_we && sh[12][1:0] == 2'b01 &&
    sh[3][1] && !six_bit_sync |-> fifo_data != sh[4])
    else $error("sync byte loaded");
  cover property (tx_irq);
  cover property (ext_irq);
  cover property (fifo_we && sh[12][1:0] == 2'b01);
endmodule : srcv_ctrl_asserts
bind srcv_ctrl srcv_ctrl_asserts i_srcv_ctrl_asserts (
  .clock, .rst, .chan_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .ext_in, .tx_empty_evt,
  .local_loop, .six_bit_sync, .tx_irq, .ext_irq, .rx_gate, .fifo_we,
  .fifo_data
);

// file: dv/srcv_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "srcv_map.svh"
module srcv_ctrl_tb_top
  import srcv_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic chan_rst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic local_loop = 1'b0;
  logic tx_byte_busy = 1'b0;
  logic auto_echo = 1'b0;
  logic six_bit_sync = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, rx_bit_valid, rx_bit, tx_irq, ext_irq, rx_irq;
  logic tx_gate, rx_gate, fifo_we, crc_we;
  logic [7:0] fifo_data, crc_data;
  logic [2:0] evt;
  srcv_ext_s ext_in;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] chr [4] = '{8'h15, 8'h41, 8'h21, 8'hA5};
  logic [7:0] fill [4] = '{8'hF5, 8'hC1, 8'hE1, 8'hA5};
  int nb [4] = '{5, 7, 6, 8};
  always #10 clock = ~clock;
  srcv_ctrl i_srcv_ctrl (
    .clock, .rst, .chan_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
    .ext_in, .tx_empty_evt(evt[2]), .rx_bit_valid, .rx_bit,
    .rx_flag_evt(evt[0]), .rx_abort_evt(evt[1]), .tx_byte_busy,
    .local_loop, .auto_echo, .six_bit_sync, .tx_irq,
    .ext_irq, .rx_irq, .tx_gate, .rx_gate, .fifo_we, .fifo_data, .crc_we,
    .crc_data
  );
  srcv_line_model i_srcv_line_model (
    .clock, .ext_in, .rx_bit_valid, .rx_bit, .evt
  );
  // ------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 8'h00);
    cmp(nm, e, rd & m);
  endtask : rdc
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic close_out();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // Generous ceiling; the whole sequence needs about 180 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc("vec_rst", `SRCV_A_VEC, 32'hFFFFFFFF, 32'h0);
    rdc("rxp_rst", `SRCV_A_RXP, 32'hFFFFFFFF, 32'h0);
    rdc("unmapped", 8'h00, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, `SRCV_A_VEC, 8'hA5);
    rdc("vec_a", `SRCV_A_VEC, 32'hFFFFFFFF, 32'hA5);
    rdc("vec_b_low", `SRCV_A_VECB, 32'hFFFFFFF1, 32'hA1);
    ahb(1'b1, `SRCV_A_MIC, 8'h11);
    rdc("vec_b_high", `SRCV_A_VECB, 32'hFFFFFF8F, 32'h85);
    ahb(1'b1, `SRCV_A_RXP, 8'hC6);
    rdc("rpr_off", `SRCV_A_RPR, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, `SRCV_A_XSE, 8'h01);
    rdc("rpr_half", `SRCV_A_RPR, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, `SRCV_A_XOP, 8'h40);
    rdc("rpr_on", `SRCV_A_RPR, 32'hFFFFFFFF, 32'hC6);
    ahb(1'b1, `SRCV_A_ITM, 8'h02);
    i_srcv_line_model.fire(3'h4);
    #1 cmp("tx_irq_on", 32'h1, {31'h0, tx_irq});
    ahb(1'b1, `SRCV_A_ITM, 8'h00);
    i_srcv_line_model.fire(3'h4);
    #1 cmp("tx_irq_off", 32'h0, {31'h0, tx_irq});
    ahb(1'b1, `SRCV_A_MOD, 8'h01);
    ahb(1'b1, `SRCV_A_ITM, 8'h01);
    ahb(1'b1, `SRCV_A_XSE, 8'h11);
    ahb(1'b1, `SRCV_A_RXP, 8'hD1);
    rdc("hunt_set", `SRCV_A_LST, 32'h10, 32'h10);
    i_srcv_line_model.fire(3'h1);
    #1 cmp("sync_irq", 32'h1, {31'h0, ext_irq});
    // Hunt status trails the state by a cycle
    settle(1);
    rdc("hunt_clr", `SRCV_A_LST, 32'h10, 32'h0);
    ahb(1'b1, `SRCV_A_SYN, 8'h81);
    ahb(1'b1, `SRCV_A_RXP, 8'hCB);
    i_srcv_line_model.send_bits(8'h81, 8);
    #1 cmp("strip_we", 32'h0, {30'h0, fifo_we, crc_we});
    i_srcv_line_model.send_bits(8'hA5, 8);
    #1 cmp("slice", 32'h3A5, {22'h0, fifo_we, crc_we, fifo_data});
    ahb(1'b1, `SRCV_A_MOD, 8'h02);
    six_bit_sync <= 1'b1;
    i_srcv_line_model.send_bits(8'h81, 8);
    #1 cmp("bisync6_keep", 32'h181, {23'h0, fifo_we, fifo_data});
    six_bit_sync <= 1'b0;
    ahb(1'b1, `SRCV_A_MOD, 8'h03);
    ahb(1'b1, `SRCV_A_RXP, 8'hC7);
    i_srcv_line_model.fire(3'h1);
    i_srcv_line_model.send_bits(8'h55, 8);
    #1 cmp("addr_miss", 32'h0, {29'h0, fifo_we, rx_irq, crc_we});
    i_srcv_line_model.fire(3'h1);
    i_srcv_line_model.send_bits(8'h8C, 8);
    #1 cmp("addr_hit", 32'h78C,
           {21'h0, fifo_we, rx_irq, crc_we, fifo_data});
    cmp("crc_lag", 32'h81, {24'h0, crc_data});
    i_srcv_line_model.fire(3'h2);
    settle(1);
    rdc("abort_hunt", `SRCV_A_LST, 32'h10, 32'h10);
    chan_rst <= 1'b1;
    @(posedge clock);
    chan_rst <= 1'b0;
    rdc("rxen_crst", `SRCV_A_RXP, 32'h01, 32'h0);
    ahb(1'b1, `SRCV_A_RXP, 8'hC1);
    i_srcv_line_model.fire(3'h1);
    #1 cmp("master_crst", 32'h0, {31'h0, ext_irq});
    ahb(1'b1, `SRCV_A_MOD, 8'h00);
    ahb(1'b1, `SRCV_A_RXP, 8'h21);
    settle(2);
    cmp("auto_dcd_lo", 32'h0, {31'h0, rx_gate});
    i_srcv_line_model.set_ext(6'h20);
    settle(2);
    cmp("auto_dcd_hi", 32'h1, {31'h0, rx_gate});
    cmp("auto_cts_lo", 32'h0, {31'h0, tx_gate});
    tx_byte_busy <= 1'b1;
    settle(2);
    cmp("cts_finish", 32'h1, {31'h0, tx_gate});
    tx_byte_busy <= 1'b0;
    auto_echo <= 1'b1;
    settle(2);
    cmp("echo_cts", 32'h1, {31'h0, tx_gate});
    auto_echo <= 1'b0;
    i_srcv_line_model.set_ext(6'h10);
    settle(2);
    cmp("auto_cts_hi", 32'h1, {31'h0, tx_gate});
    i_srcv_line_model.set_ext(6'h00);
    local_loop <= 1'b1;
    settle(2);
    cmp("loop_ignore", 32'h1, {31'h0, rx_gate});
    cmp("loop_cts", 32'h1, {31'h0, tx_gate});
    local_loop <= 1'b0;
    ahb(1'b1, `SRCV_A_RXP, 8'h01);
    settle(2);
    cmp("no_auto", 32'h1, {31'h0, rx_gate});
    cmp("no_auto_tx", 32'h1, {31'h0, tx_gate});
    i_srcv_line_model.set_ext(6'h20);
    settle(2);
    rdc("dcd_status", `SRCV_A_LST, 32'h08, 32'h08);
    for (int k = 0; k < 4; k++) begin
      ahb(1'b1, `SRCV_A_RXP, {k[1:0], 6'h09});
      i_srcv_line_model.send_bits(chr[k], nb[k]);
      #1 cmp("async_char", {23'h0, 1'b1, fill[k]},
             {23'h0, fifo_we, fifo_data});
      cmp("async_crc", 32'h0, {31'h0, crc_we});
    end
    close_out();
  end
endmodule : srcv_ctrl_tb_top

// file: dv/srcv_line_model.sv
`timescale 1ns/1ps
module srcv_line_model
  import srcv_pkg::*;
(
  input wire logic clock,
  output srcv_ext_s ext_in,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic [2:0] evt
);
  // ------------------------------------------------
  // Serial line side: modem levels, bits, line events
  // ------------------------------------------------
  initial begin
    ext_in = '0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b1;
    evt = 3'h0;
  end
  // Low bit first; idle line inverts so stale data never looks valid
  task automatic send_bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      rx_bit_valid <= 1'b1;
      rx_bit <= v[i];
      @(posedge clock);
    end
    rx_bit_valid <= 1'b0;
    rx_bit <= ~v[n-1];
  endtask : send_bits
  // One-cycle event pulse: {tx empty, abort, sync or flag match}
  task automatic fire(input logic [2:0] sel);
    evt <= sel;
    @(posedge clock);
    evt <= 3'h0;
  endtask : fire
  task automatic set_ext(input srcv_ext_s v);
    ext_in <= v;
  endtask : set_ext
endmodule : srcv_line_model

// file: src/srcv_ctrl.sv
`timescale 1ns/1ps
`include "srcv_map.svh"
module srcv_ctrl
  import srcv_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chan_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire srcv_ext_s ext_in,
  input wire logic tx_empty_evt,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_flag_evt,
  input wire logic rx_abort_evt,
  input wire logic tx_byte_busy,
  input wire logic local_loop,
  input wire logic auto_echo,
  input wire logic six_bit_sync,
  output logic tx_irq,
  output logic ext_irq,
  output logic rx_irq,
  output logic tx_gate,
  output logic rx_gate,
  output logic fifo_we,
  output logic [7:0] fifo_data,
  output logic crc_we,
  output logic [7:0] crc_data
);
  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [7:0] itm_reg, vec_reg, rxp_reg, syn_reg, xop_reg, mic_reg, xse_reg;
  logic [7:0] mod_reg;
  logic [7:0] rxd_reg;
  logic [7:0] crc_src_reg;
  logic wp_reg;
  logic [7:0] wa_reg;
  logic [2:0] evt_reg;
  srcv_state_e state_reg;
  logic hunt_stat_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic addr_phase_reg;
  logic addr_ok_reg;
  logic sync_seen_reg;
  logic tx_run_reg;
  srcv_mode_e mode;
  logic take;
  logic cres;
  assign mode = srcv_mode_e'(mod_reg[1:0]);
  assign take = hsel && hready && htrans[1];
  assign cres = chan_rst;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_reg <= 1'b0;
      wa_reg <= `SRCV_ZERO8;
    end else begin
      wp_reg <= take && hwrite;
      wa_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      itm_reg <= `SRCV_ZERO8;
      vec_reg <= `SRCV_ZERO8;
      syn_reg <= `SRCV_ZERO8;
      xop_reg <= `SRCV_ZERO8;
      mic_reg <= `SRCV_ZERO8;
      xse_reg <= `SRCV_ZERO8;
      mod_reg <= `SRCV_ZERO8;
    end else if (cres) begin
      itm_reg[`SRCV_B_XIE] <= 1'b0;
    end else if (wp_reg) begin
      case (wa_reg)
        `SRCV_A_ITM: itm_reg <= hwdata[7:0];
        `SRCV_A_VEC, `SRCV_A_VECB: vec_reg <= hwdata[7:0];
        `SRCV_A_SYN: syn_reg <= hwdata[7:0];
        `SRCV_A_XOP: xop_reg <= hwdata[7:0];
        `SRCV_A_MIC: mic_reg <= hwdata[7:0];
        `SRCV_A_XSE: xse_reg <= hwdata[7:0];
        `SRCV_A_MOD: mod_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Hunt bit is a command: self-clears, never stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxp_reg <= `SRCV_ZERO8;
    end else if (cres) begin
      rxp_reg[`SRCV_B_RXEN] <= 1'b0;
    end else if (wp_reg && wa_reg == `SRCV_A_RXP) begin
      rxp_reg <= hwdata[7:0] & ~(8'h01 << `SRCV_B_HUNT);
    end
  end

  // Status field for channel B vector
  logic [2:0] vstat;
  logic [7:0] vec_b;
  always_comb begin
    vstat = evt_reg;
    vec_b = vec_reg;
    if (mic_reg[`SRCV_B_SHL]) begin
      vec_b[6:4] = {vstat[0], vstat[1], vstat[2]};
    end else begin
      vec_b[3:1] = vstat;
    end
  end

  logic rdok;
  assign rdok = xse_reg[`SRCV_B_RDEN] && xop_reg[`SRCV_B_XRD];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        `SRCV_A_VEC: hrdata <= {24'h0, vec_reg};
        `SRCV_A_VECB: hrdata <= {24'h0, vec_b};
        `SRCV_A_RPR: hrdata <= rdok ? {24'h0, rxp_reg} : 32'h0;
        `SRCV_A_LST: hrdata <= {24'h0, 2'b00, ext_in.cts, hunt_stat_reg,
                                ext_in.dcd, 3'b000};
        `SRCV_A_RXD: hrdata <= {24'h0, rxd_reg};
        `SRCV_A_SYN: hrdata <= {24'h0, syn_reg};
        `SRCV_A_MOD: hrdata <= {24'h0, mod_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Modem gating
  // ---------------------------------------------------------------
  logic cts_use, dcd_use;
  assign cts_use = !(local_loop || auto_echo);
  assign dcd_use = !local_loop;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_run_reg <= 1'b0;
      tx_gate <= 1'b0;
      rx_gate <= 1'b0;
    end else begin
      tx_run_reg <= tx_byte_busy;
      if (rxp_reg[`SRCV_B_AUTO]) begin
        // Byte in flight keeps the gate open
        tx_gate <= (ext_in.cts || !cts_use || tx_byte_busy);
        rx_gate <= rxp_reg[`SRCV_B_RXEN] && (ext_in.dcd || !dcd_use);
      end else begin
        tx_gate <= 1'b1;
        rx_gate <= rxp_reg[`SRCV_B_RXEN];
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive assembly
  // ---------------------------------------------------------------
  logic [3:0] len;
  always_comb begin
    case (rxp_reg[7:6])
      2'b00: len = 4'd5;
      2'b01: len = 4'd7;
      2'b10: len = 4'd6;
      default: len = 4'd8;
    endcase
  end

  logic hunt_cmd, bound;
  logic [7:0] nxt_sh, byte_out, sync_cmp;
  logic is_sync, strip, abort_or_off;
  assign hunt_cmd = wp_reg && wa_reg == `SRCV_A_RXP && hwdata[`SRCV_B_HUNT];
  assign abort_or_off = rx_abort_evt || !rx_gate;
  assign nxt_sh = {rx_bit, sh_reg[7:1]};
  // Async takes the programmed length, sync modes a whole byte
  assign bound = rx_bit_valid && state_reg == SRCV_SYNCED &&
    (cnt_reg + 4'd1 >= ((mode == SRCV_ASYNC) ? len : 4'd8));
  always_comb begin
    byte_out = nxt_sh;
    if (mode == SRCV_ASYNC) begin
      byte_out = (nxt_sh >> (4'd8 - len)) | (`SRCV_ONES8 << len);
    end
  end
  assign is_sync = nxt_sh == syn_reg;
  always_comb begin
    strip = 1'b0;
    if (mode == SRCV_MONO && rxp_reg[`SRCV_B_SLI] && is_sync) begin
      strip = 1'b1;
    end
    if (mode == SRCV_BISYNC && rxp_reg[`SRCV_B_SLI] && is_sync &&
        !six_bit_sync) begin
      strip = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= SRCV_IDLE;
    end else if (cres || abort_or_off) begin
      state_reg <= SRCV_HUNT;
    end else if (state_reg == SRCV_IDLE) begin
      state_reg <= (mode == SRCV_ASYNC) ? SRCV_SYNCED : SRCV_HUNT;
    end else if (hunt_cmd && mode != SRCV_ASYNC) begin
      state_reg <= SRCV_HUNT;
    end else begin
      case (state_reg)
        SRCV_HUNT: if (mode == SRCV_ASYNC || rx_flag_evt)
          state_reg <= SRCV_SYNCED;
        SRCV_SYNCED: ;
        default: state_reg <= SRCV_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hunt_stat_reg <= 1'b1;
    end else begin
      hunt_stat_reg <= state_reg != SRCV_SYNCED;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'd0;
      sh_reg <= `SRCV_ZERO8;
    end else if (state_reg != SRCV_SYNCED) begin
      cnt_reg <= 4'd0;
    end else if (rx_bit_valid) begin
      sh_reg <= nxt_sh;
      cnt_reg <= bound ? 4'd0 : cnt_reg + 4'd1;
    end
  end

  // SDLC address filter on first byte of frame
  logic addr_match;
  assign addr_match = rxp_reg[`SRCV_B_SLI] ?
    (nxt_sh[7:4] == syn_reg[7:4]) : (nxt_sh == syn_reg);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_phase_reg <= 1'b0;
      addr_ok_reg <= 1'b1;
    end else if (rx_flag_evt) begin
      addr_phase_reg <= 1'b1;
      addr_ok_reg <= !(mode == SRCV_SDLC && rxp_reg[`SRCV_B_ADS]);
    end else if (bound && addr_phase_reg) begin
      addr_phase_reg <= 1'b0;
      if (mode == SRCV_SDLC && rxp_reg[`SRCV_B_ADS]) begin
        addr_ok_reg <= addr_match;
      end
    end
  end

  logic load;
  assign load = bound && !strip &&
    (addr_ok_reg || (addr_phase_reg && addr_match) ||
     !(mode == SRCV_SDLC && rxp_reg[`SRCV_B_ADS]));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_we <= 1'b0;
      fifo_data <= `SRCV_ZERO8;
      rxd_reg <= `SRCV_ZERO8;
      rx_irq <= 1'b0;
    end else begin
      fifo_we <= load;
      rx_irq <= load;
      if (load) begin
        fifo_data <= byte_out;
        rxd_reg <= byte_out;
      end
    end
  end

  // CRC runs one byte behind the FIFO load
  logic crc_on;
  assign crc_on = mode == SRCV_SDLC ||
    (mode != SRCV_ASYNC && rxp_reg[`SRCV_B_CRC]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc_we <= 1'b0;
      crc_data <= `SRCV_ZERO8;
      crc_src_reg <= `SRCV_ZERO8;
      sync_seen_reg <= 1'b0;
    end else begin
      crc_we <= load && crc_on;
      sync_seen_reg <= strip;
      if (load) begin
        crc_src_reg <= byte_out;
        crc_data <= crc_src_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic ext_any;
  always_comb begin
    ext_any = (ext_in.dcd && xse_reg[`SRCV_B_DCDIE]) ||
      (ext_in.cts && xse_reg[`SRCV_B_CTSIE]) ||
      ((ext_in.sync || (rx_flag_evt && state_reg == SRCV_HUNT)) &&
       xse_reg[`SRCV_B_SYNIE]) ||
      (ext_in.brk && xse_reg[`SRCV_B_BRKIE]) ||
      (ext_in.und && xse_reg[`SRCV_B_UNDIE]) ||
      (ext_in.zc && xse_reg[`SRCV_B_ZCIE]);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_irq <= 1'b0;
      ext_irq <= 1'b0;
      evt_reg <= 3'b000;
    end else begin
      tx_irq <= tx_empty_evt && itm_reg[`SRCV_B_TIE];
      ext_irq <= ext_any && itm_reg[`SRCV_B_XIE];
      if (tx_empty_evt && itm_reg[`SRCV_B_TIE]) begin
        evt_reg <= 3'b000;
      end else if (ext_any && itm_reg[`SRCV_B_XIE]) begin
        evt_reg <= 3'b101;
      end else if (load) begin
        evt_reg <= 3'b010;
      end
    end
  end
endmodule : srcv_ctrl

// file: src/srcv_map.svh
// Contract
// - Transmit interrupt enable raises request whenever transmit buffer empties.
// - External/status master enable gates all ext sources; resets clear it.
// - One vector register shared by both channels, reachable from either.
// - Channel A vector read returns stored value unmodified.
// - Channel B read substitutes status in bits 3:1 or 6:4, ignoring VECTOR_INCLUDES_STATUS.
// - Length field 00=5,01=7,10=6,11=8 bits; change valid before count reached.
// - Async characters shorter than eight bits get upper bits filled with ones.
// - Sync and SDLC modes move eight-bit slices into FIFO per boundary.
// - Auto enables plus enable bits: CTS gates transmitter, DCD gates receiver.
// - Without auto enables inputs only feed status; loopback ignores both, echo ignores CTS only.
// - CTS drop mid-byte lets the transmitter finish that byte.
// - Enter-hunt forces sync search; reset starts hunt except in async.
// - Sync or flag match clears hunt status and may raise ext interrupt.
// - Receiver re-enters hunt on abort or when disabled.
// - CRC enable starts from last byte moved to FIFO; host clears beforehand.
// - SDLC forces CRC on over unstuffed bits; async ignores CRC enable.
// - SDLC address search discards mismatched frames, no receive interrupts.
// - Load inhibit with address search compares upper four address bits only.
// - Non-SDLC sync load inhibit drops bytes equal to sync byte, no CRC.
// - Six-bit sync strips all but last sync (monosync here strips every sync); bisync six-bit ignores inhibit.
// - Receiver enable starts reception; resets clear it; host sets it last.
// - Receive parameters readable via alternate register when both gates set.
`ifndef SRCV_MAP_SVH
`define SRCV_MAP_SVH
`define SRCV_A_ITM 8'h04
`define SRCV_A_VEC 8'h08
`define SRCV_A_RXP 8'h0C
`define SRCV_A_SYN 8'h10
`define SRCV_A_XOP 8'h14
`define SRCV_A_MIC 8'h18
`define SRCV_A_XSE 8'h1C
`define SRCV_A_LST 8'h20
`define SRCV_A_RXD 8'h24
`define SRCV_A_RPR 8'h28
`define SRCV_A_VECB 8'h2C
`define SRCV_A_MOD 8'h30
`define SRCV_A_RXS 8'h34
`define SRCV_A_RST 8'h38
`define SRCV_A_EVT 8'h3C
`define SRCV_B_XIE 0
`define SRCV_B_TIE 1
`define SRCV_B_RXEN 0
`define SRCV_B_SLI 1
`define SRCV_B_ADS 2
`define SRCV_B_CRC 3
`define SRCV_B_HUNT 4
`define SRCV_B_AUTO 5
`define SRCV_B_SHL 4
`define SRCV_B_VIS 0
`define SRCV_B_RDEN 0
`define SRCV_B_XRD 6
`define SRCV_B_DCDIE 3
`define SRCV_B_SYNIE 4
`define SRCV_B_CTSIE 5
`define SRCV_B_UNDIE 6
`define SRCV_B_BRKIE 7
`define SRCV_B_ZCIE 1
`define SRCV_ZERO8 8'h00
`define SRCV_ONES8 8'hFF
`endif

// file: src/srcv_pkg.sv
package srcv_pkg;
  typedef enum logic [1:0] {SRCV_ASYNC, SRCV_MONO, SRCV_BISYNC, SRCV_SDLC}
    srcv_mode_e;
  typedef enum logic [1:0] {SRCV_HUNT, SRCV_SYNCED, SRCV_IDLE} srcv_state_e;
  typedef struct packed {
    logic dcd;
    logic cts;
    logic sync;
    logic brk;
    logic und;
    logic zc;
  } srcv_ext_s;
endpackage : srcv_pkg
